// file: inc/ccde_cfg.svh
// Functional notes
// - A call pushes the address after the call onto the return stack first.
// - Call loads an 11-bit target into pc 10:0, page latch 4:3 into 12:11.
// - A call takes two instruction cycles and changes no status flag.
// - Watchdog clear zeroes the watchdog counter and its prescaler.
// - Watchdog clear sets timeout and power-down flags to one, nothing else.
// - File clear writes zero into the 7-bit addressed register and sets zero flag.
// - Invert complements a register; destination bit picks accumulator or register; zero flag only.
// - Accumulator clear writes zero to the accumulator and sets zero flag.
// - Decrement subtracts one, routes by destination bit, updates only zero flag.
// - Decrement-skip subtracts one, routes by destination bit, changes no flag.
// - A zero decrement-skip result replaces the next instruction by a no-operation.
`ifndef CCDE_CFG_SVH
`define CCDE_CFG_SVH
`define CCDE_A_INSN 8'h00
`define CCDE_A_ACCUM 8'h04
`define CCDE_A_STATUS 8'h08
`define CCDE_A_PC 8'h0c
`define CCDE_A_PLAT 8'h10
`define CCDE_A_STACK 8'h14
`define CCDE_A_WDOG 8'h18
`define CCDE_A_FADDR 8'h1c
`define CCDE_A_FDATA 8'h20
`define CCDE_A_EXST 8'h24
`define CCDE_ST_Z 2
`define CCDE_ST_PD 3
`define CCDE_ST_TO 4
`define CCDE_OPC_CALL 3'h4
`define CCDE_OPC_WDCLR 14'h0064
`define CCDE_OPC_NOP 14'h0000
`define CCDE_OPC_FCLR 7'h03
`define CCDE_OPC_ACLR 7'h02
`define CCDE_OPC_FINV 6'h09
`define CCDE_OPC_FDEC 6'h03
`define CCDE_OPC_DSKZ 6'h0b
`define CCDE_RESP_OKAY 2'h0
`define CCDE_RESP_SLVERR 2'h2
`define CCDE_CYC_DIV 4
`endif

// file: inc/ccde_pkg.sv
package ccde_pkg;
  typedef enum logic [3:0] {
    CCDE_OP_NOP = 4'h0,
    CCDE_OP_CALL = 4'h1,
    CCDE_OP_WDCLR = 4'h3,
    CCDE_OP_FCLR = 4'h2,
    CCDE_OP_ACLR = 4'h6,
    CCDE_OP_FINV = 4'h7,
    CCDE_OP_FDEC = 4'h5,
    CCDE_OP_DSKZ = 4'h4,
    CCDE_OP_ILL = 4'hc
  } ccde_op_e;
  typedef logic [12:0] ccde_pc_t;
endpackage

// file: design/ccde_core.sv
`timescale 1ns/1ns
`include "ccde_cfg.svh"
module ccde_core #(
  parameter int CYC_DIV = `CCDE_CYC_DIV,
  parameter int STK_DEPTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  localparam int SPW = $clog2(STK_DEPTH);

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [31:0] wdat;
    logic [3:0] wstb;
    logic [7:0] div;
    logic [13:0] insn;
    logic pending;
    logic hold2;
    logic skip_cyc;
    logic illegal;
    logic [7:0] accum;
    logic z;
    logic pd;
    logic timeout_flag;
    ccde_pkg::ccde_pc_t pc;
    logic [7:0] program_page_latch;
    logic [SPW-1:0] sp;
    logic [STK_DEPTH-1:0][12:0] stack;
    logic [7:0] watchdog_counter;
    logic [7:0] presc;
    logic [6:0] faddr;
    logic [127:0][7:0] mem;
  } ccde_state_s;

  ccde_state_s s_r;
  ccde_state_s s_nxt;

  ccde_pkg::ccde_op_e op;
  logic tick;
  logic go;
  logic [6:0] fsel;
  logic dsel;
  logic [7:0] opnd;
  logic [7:0] dec_res;
  logic busy;
  logic [12:0] stack_top;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] stb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (stb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    if (s_r.insn[13:11] == `CCDE_OPC_CALL) begin
      op = ccde_pkg::CCDE_OP_CALL;
    end else if (s_r.insn == `CCDE_OPC_WDCLR) begin
      op = ccde_pkg::CCDE_OP_WDCLR;
    end else if (s_r.insn[13:7] == `CCDE_OPC_FCLR) begin
      op = ccde_pkg::CCDE_OP_FCLR;
    end else if (s_r.insn[13:7] == `CCDE_OPC_ACLR) begin
      op = ccde_pkg::CCDE_OP_ACLR;
    end else if (s_r.insn[13:8] == `CCDE_OPC_FINV) begin
      op = ccde_pkg::CCDE_OP_FINV;
    end else if (s_r.insn[13:8] == `CCDE_OPC_FDEC) begin
      op = ccde_pkg::CCDE_OP_FDEC;
    end else if (s_r.insn[13:8] == `CCDE_OPC_DSKZ) begin
      op = ccde_pkg::CCDE_OP_DSKZ;
    end else if (s_r.insn == `CCDE_OPC_NOP) begin
      op = ccde_pkg::CCDE_OP_NOP;
    end else begin
      op = ccde_pkg::CCDE_OP_ILL;
    end
  end

  // The instruction clock is a one-cycle enable taken from the bus clock.
  assign tick = (s_r.div == 8'(CYC_DIV - 1));
  assign go = tick && s_r.pending && !s_r.hold2;
  assign fsel = s_r.insn[6:0];
  assign dsel = s_r.insn[7];
  assign opnd = s_r.mem[fsel];
  assign dec_res = opnd - 8'h01;
  assign busy = s_r.pending || s_r.hold2;
  assign stack_top = s_r.stack[s_r.sp - SPW'(1)];

  always_comb begin
    logic [7:0] res;
    logic [7:0] ra;
    logic [31:0] wv;
    logic [31:0] rv;
    logic wr_do;
    res = 8'h00;
    ra = 8'h00;
    wv = 32'h0;
    rv = 32'h0;
    wr_do = 1'b0;
    s_nxt = s_r;
    s_nxt.div = tick ? 8'h00 : s_r.div + 8'h01;
    if (tick) begin
      s_nxt.presc = s_r.presc + 8'h01;
      if (s_r.presc == 8'hff) begin
        s_nxt.watchdog_counter = s_r.watchdog_counter + 8'h01;
      end
    end
    if (tick && s_r.hold2) begin
      // Second cycle of a call, or the no-operation that replaces a skipped instruction.
      s_nxt.hold2 = 1'b0;
      s_nxt.skip_cyc = 1'b0;
    end else if (go) begin
      s_nxt.pending = 1'b0;
      s_nxt.pc = s_r.pc + 13'h0001;
      case (op)
        ccde_pkg::CCDE_OP_CALL: begin
          s_nxt.stack[s_r.sp] = s_r.pc + 13'h0001;
          s_nxt.sp = s_r.sp + SPW'(1);
          s_nxt.pc = {s_r.program_page_latch[4:3], s_r.insn[10:0]};
          s_nxt.hold2 = 1'b1;
        end
        ccde_pkg::CCDE_OP_WDCLR: begin
          s_nxt.watchdog_counter = 8'h00;
          s_nxt.presc = 8'h00;
          s_nxt.timeout_flag = 1'b1;
          s_nxt.pd = 1'b1;
        end
        ccde_pkg::CCDE_OP_FCLR: begin
          s_nxt.mem[fsel] = 8'h00;
          s_nxt.z = 1'b1;
        end
        ccde_pkg::CCDE_OP_ACLR: begin
          s_nxt.accum = 8'h00;
          s_nxt.z = 1'b1;
        end
        ccde_pkg::CCDE_OP_FINV, ccde_pkg::CCDE_OP_FDEC, ccde_pkg::CCDE_OP_DSKZ: begin
          res = (op == ccde_pkg::CCDE_OP_FINV) ? ~opnd : dec_res;
          if (dsel) begin
            s_nxt.mem[fsel] = res;
          end else begin
            s_nxt.accum = res;
          end
          if (op != ccde_pkg::CCDE_OP_DSKZ) begin
            s_nxt.z = (res == 8'h00);
          end else if (res == 8'h00) begin
            s_nxt.hold2 = 1'b1;
            s_nxt.skip_cyc = 1'b1;
            s_nxt.pc = s_r.pc + 13'h0002;
          end
        end
        default: begin
          s_nxt.illegal = (op == ccde_pkg::CCDE_OP_ILL);
        end
      endcase
    end

    // Write channel: address and data are caught in either order.
    if (awvalid && s_r.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awready = 1'b0;
      s_nxt.waddr = awaddr;
    end
    if (wvalid && s_r.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wready = 1'b0;
      s_nxt.wdat = wdata;
      s_nxt.wstb = wstrb;
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready = 1'b1;
    end
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `CCDE_RESP_OKAY;
      ra = s_r.waddr & 8'hfc;
      // State registers are locked while an instruction runs so that software cannot race it.
      wr_do = !busy;
      if (ra == `CCDE_A_INSN) begin
        wv = merge({18'h0, s_r.insn}, s_r.wdat, s_r.wstb);
        if (wr_do) begin
          s_nxt.insn = wv[13:0];
          s_nxt.pending = 1'b1;
          s_nxt.illegal = 1'b0;
        end
      end else if (ra == `CCDE_A_ACCUM) begin
        wv = merge({24'h0, s_r.accum}, s_r.wdat, s_r.wstb);
        if (wr_do) s_nxt.accum = wv[7:0];
      end else if (ra == `CCDE_A_STATUS) begin
        wv = merge({27'h0, s_r.timeout_flag, s_r.pd, s_r.z, 2'h0}, s_r.wdat, s_r.wstb);
        if (wr_do) {s_nxt.timeout_flag, s_nxt.pd, s_nxt.z} = wv[`CCDE_ST_TO:`CCDE_ST_Z];
      end else if (ra == `CCDE_A_PC) begin
        wv = merge({19'h0, s_r.pc}, s_r.wdat, s_r.wstb);
        if (wr_do) s_nxt.pc = wv[12:0];
      end else if (ra == `CCDE_A_PLAT) begin
        wv = merge({24'h0, s_r.program_page_latch}, s_r.wdat, s_r.wstb);
        if (wr_do) s_nxt.program_page_latch = wv[7:0];
      end else if (ra == `CCDE_A_WDOG) begin
        wv = merge({16'h0, s_r.presc, s_r.watchdog_counter}, s_r.wdat, s_r.wstb);
        if (wr_do) {s_nxt.presc, s_nxt.watchdog_counter} = wv[15:0];
      end else if (ra == `CCDE_A_FADDR) begin
        wv = merge({25'h0, s_r.faddr}, s_r.wdat, s_r.wstb);
        if (wr_do) s_nxt.faddr = wv[6:0];
      end else if (ra == `CCDE_A_FDATA) begin
        wv = merge({24'h0, s_r.mem[s_r.faddr]}, s_r.wdat, s_r.wstb);
        if (wr_do) s_nxt.mem[s_r.faddr] = wv[7:0];
      end else if (ra == `CCDE_A_STACK || ra == `CCDE_A_EXST) begin
        wr_do = 1'b1;
      end else begin
        wr_do = 1'b0;
      end
      if (!wr_do) begin
        s_nxt.bresp = `CCDE_RESP_SLVERR;
      end
    end

    // Read channel: one read in flight, answered the cycle after it is taken.
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
      s_nxt.arready = 1'b1;
    end
    if (arvalid && s_r.arready) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = `CCDE_RESP_OKAY;
      ra = araddr & 8'hfc;
      if (ra == `CCDE_A_INSN) begin
        rv = {18'h0, s_r.insn};
      end else if (ra == `CCDE_A_ACCUM) begin
        rv = {24'h0, s_r.accum};
      end else if (ra == `CCDE_A_STATUS) begin
        rv = {27'h0, s_r.timeout_flag, s_r.pd, s_r.z, 2'h0};
      end else if (ra == `CCDE_A_PC) begin
        rv = {19'h0, s_r.pc};
      end else if (ra == `CCDE_A_PLAT) begin
        rv = {24'h0, s_r.program_page_latch};
      end else if (ra == `CCDE_A_STACK) begin
        rv = {12'h0, 4'(s_r.sp), 3'h0, stack_top};
      end else if (ra == `CCDE_A_WDOG) begin
        rv = {16'h0, s_r.presc, s_r.watchdog_counter};
      end else if (ra == `CCDE_A_FADDR) begin
        rv = {25'h0, s_r.faddr};
      end else if (ra == `CCDE_A_FDATA) begin
        rv = {24'h0, s_r.mem[s_r.faddr]};
      end else if (ra == `CCDE_A_EXST) begin
        rv = {28'h0, s_r.skip_cyc, s_r.illegal, s_r.hold2, s_r.pending};
      end else begin
        s_nxt.rresp = `CCDE_RESP_SLVERR;
      end
      s_nxt.rdata = rv;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      {s_r.awready, s_r.wready, s_r.arready} <= 3'b111;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign awready = s_r.awready;
  assign wready = s_r.wready;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign arready = s_r.arready;
  assign rvalid = s_r.rvalid;
  assign rdata = s_r.rdata;
  assign rresp = s_r.rresp;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [2:0] stat_bits;
  assign stat_bits = {s_r.timeout_flag, s_r.pd, s_r.z};

  property p_call_push;
    go && op == ccde_pkg::CCDE_OP_CALL |=> stack_top == $past(s_r.pc) + 13'h0001;
  endproperty
  a_call_push: assert property (p_call_push) else $error("call pushed a wrong return address");
  property p_call_target;
    go && op == ccde_pkg::CCDE_OP_CALL |=> s_r.pc == {$past(s_r.program_page_latch[4:3]), $past(s_r.insn[10:0])};
  endproperty
  a_call_target: assert property (p_call_target) else $error("call formed a wrong program counter");
  property p_call_two;
    go && op == ccde_pkg::CCDE_OP_CALL |=> s_r.hold2 && stat_bits == $past(stat_bits) ##CYC_DIV !s_r.hold2;
  endproperty
  a_call_two: assert property (p_call_two) else $error("call did not take two cycles or changed status");
  property p_wd_clear;
    go && op == ccde_pkg::CCDE_OP_WDCLR |=> s_r.watchdog_counter == 8'h00 && s_r.presc == 8'h00;
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("watchdog clear left a count");
  property p_wd_flags;
    go && op == ccde_pkg::CCDE_OP_WDCLR |=> s_r.timeout_flag && s_r.pd && s_r.z == $past(s_r.z);
  endproperty
  a_wd_flags: assert property (p_wd_flags) else $error("watchdog clear flags wrong");
  property p_fclr;
    go && op == ccde_pkg::CCDE_OP_FCLR |=> s_r.mem[$past(fsel)] == 8'h00 && s_r.z;
  endproperty
  a_fclr: assert property (p_fclr) else $error("file clear wrong");
  property p_finv;
    go && op == ccde_pkg::CCDE_OP_FINV && dsel |=> s_r.mem[$past(fsel)] == ~$past(opnd);
  endproperty
  a_finv: assert property (p_finv) else $error("invert result wrong");
  property p_aclr;
    go && op == ccde_pkg::CCDE_OP_ACLR |=> s_r.accum == 8'h00 && s_r.z;
  endproperty
  a_aclr: assert property (p_aclr) else $error("accumulator clear wrong");
  property p_fdec;
    go && op == ccde_pkg::CCDE_OP_FDEC && !dsel |=> s_r.accum == $past(opnd) - 8'h01;
  endproperty
  a_fdec: assert property (p_fdec) else $error("decrement result wrong");
  property p_dskz_flags;
    go && op == ccde_pkg::CCDE_OP_DSKZ |=> stat_bits == $past(stat_bits);
  endproperty
  a_dskz_flags: assert property (p_dskz_flags) else $error("decrement-skip changed status");
  property p_dskz_skip;
    go && op == ccde_pkg::CCDE_OP_DSKZ |=> s_r.skip_cyc == ($past(opnd) == 8'h01) &&
      s_r.pc == $past(s_r.pc) + (s_r.skip_cyc ? 13'h0002 : 13'h0001);
  endproperty
  a_dskz_skip: assert property (p_dskz_skip) else $error("skip decision wrong");
  property p_zero;
    go && (op == ccde_pkg::CCDE_OP_FDEC || op == ccde_pkg::CCDE_OP_FINV) |=>
      s_r.z == (($past(dsel) ? s_r.mem[$past(fsel)] : s_r.accum) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  c_call: cover property (go && op == ccde_pkg::CCDE_OP_CALL);
  c_skip: cover property (go && op == ccde_pkg::CCDE_OP_DSKZ && opnd == 8'h01);
  c_wdclr: cover property (go && op == ccde_pkg::CCDE_OP_WDCLR);
  c_busy_err: cover property (s_r.bvalid && s_r.bresp == `CCDE_RESP_SLVERR);
endmodule // ccde_core

// file: test/call_clear_decrement_exec_tb.sv
`timescale 1ns/1ns
`include "ccde_cfg.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module call_clear_decrement_exec_tb;
  logic aclk;
  logic aresetn;
  logic [7:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [7:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  int n_mismatch;
  int check_count;
  int cyc;
  logic sec_seen;
  logic [31:0] v;
  logic [1:0] rs;

  ccde_core #(.CYC_DIV(4), .STK_DEPTH(8)) i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // A hung handshake would otherwise stall the run forever.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic wx(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    `CHK("bresp", er, bresp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wx(a, d, 4'hf, `CCDE_RESP_OKAY);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `CHK(n, e, d);
    `CHK("rresp", `CCDE_RESP_OKAY, r);
  endtask

  // Polling every third clock cannot miss a four-clock second cycle.
  task automatic wait_idle;
    logic [31:0] d;
    logic [1:0] r;
    sec_seen = 1'b0;
    d = 32'h3;
    for (int n = 0; n < 40 && d[1:0] != 2'b00; n++) begin
      rd(`CCDE_A_EXST, d, r);
      if (d[1]) sec_seen = 1'b1;
    end
    `CHK("exec_idle", 3'h0, d[2:0]);
  endtask

  task automatic ex(input logic [13:0] i);
    wr(`CCDE_A_INSN, {18'h0, i});
    wait_idle();
  endtask

  task automatic call_chk(input logic [12:0] pc0, input logic [7:0] pl, input logic [10:0] k, input logic [7:0] st);
    logic [31:0] d;
    logic [1:0] r;
    wr(`CCDE_A_PC, {19'h0, pc0});
    wr(`CCDE_A_PLAT, {24'h0, pl});
    wr(`CCDE_A_STATUS, {24'h0, st});
    ex({3'b100, k});
    rc(`CCDE_A_PC, {19'h0, pl[4:3], k}, "call_pc");
    rd(`CCDE_A_STACK, d, r);
    `CHK("stack_top", pc0 + 13'h0001, d[12:0]);
    rc(`CCDE_A_STATUS, {24'h0, st}, "call_status");
    `CHK("call_second", 1'b1, sec_seen);
  endtask

  task automatic alu(input logic [5:0] o, input logic dd, input logic [7:0] f, input logic [7:0] st);
    logic [7:0] r;
    logic [7:0] es;
    logic [12:0] ep;
    logic sk;
    r = (o == `CCDE_OPC_FINV) ? ~f : f - 8'h01;
    es = st;
    sk = (o == `CCDE_OPC_DSKZ) && (r == 8'h00);
    ep = sk ? 13'h0012 : 13'h0011;
    if (o != `CCDE_OPC_DSKZ) es[`CCDE_ST_Z] = (r == 8'h00);
    wr(`CCDE_A_FADDR, 32'h5);
    wr(`CCDE_A_FDATA, {24'h0, f});
    wr(`CCDE_A_ACCUM, 32'h3c);
    wr(`CCDE_A_STATUS, {24'h0, st});
    wr(`CCDE_A_PC, 32'h10);
    ex({o, dd, 7'h05});
    rc(`CCDE_A_FDATA, {24'h0, dd ? r : f}, "file");
    rc(`CCDE_A_ACCUM, {24'h0, dd ? 8'h3c : r}, "accum");
    rc(`CCDE_A_STATUS, {24'h0, es}, "alu_status");
    rc(`CCDE_A_PC, {19'h0, ep}, "alu_pc");
    `CHK("skip_second", sk, sec_seen);
  endtask

  initial begin
    aresetn = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    cyc = 0;
    sec_seen = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rc(`CCDE_A_PC, 32'h0, "pc_rst");
    wx(8'h40, 32'h1, 4'hf, `CCDE_RESP_SLVERR);
    rd(8'h40, v, rs);
    `CHK("unmapped", 34'h200000000, {rs, v});
    wr(`CCDE_A_PC, 32'h12);
    wx(`CCDE_A_PC, 32'h0a00, 4'h2, `CCDE_RESP_OKAY);
    rc(`CCDE_A_PC, 32'h0a12, "pc_strobe");
    $display("test bus done");
    call_chk(13'h0123, 8'h18, 11'h7ff, 8'h1c);
    call_chk(13'h0abc, 8'hef, 11'h000, 8'h00);
    $display("test call done");
    wr(`CCDE_A_WDOG, 32'h5a34);
    wr(`CCDE_A_STATUS, 32'h4);
    ex(`CCDE_OPC_WDCLR);
    rd(`CCDE_A_WDOG, v, rs);
    `CHK("wdt_cnt", 8'h00, v[7:0]);
    `CHK("wdt_pre", 1'b1, v[15:8] < 8'h08);
    rc(`CCDE_A_STATUS, 32'h1c, "wdclr_st");
    wr(`CCDE_A_STATUS, 32'h0);
    ex(`CCDE_OPC_WDCLR);
    rc(`CCDE_A_STATUS, 32'h18, "wdclr_st0");
    $display("test watchdog done");
    wr(`CCDE_A_FADDR, 32'h7f);
    wr(`CCDE_A_FDATA, 32'h55);
    wr(`CCDE_A_STATUS, 32'h18);
    ex(14'h01ff);
    rc(`CCDE_A_FDATA, 32'h0, "fclr");
    rc(`CCDE_A_STATUS, 32'h1c, "fclr_st");
    wr(`CCDE_A_ACCUM, 32'ha5);
    wr(`CCDE_A_STATUS, 32'h0);
    ex(14'h0100);
    rc(`CCDE_A_ACCUM, 32'h0, "aclr");
    rc(`CCDE_A_STATUS, 32'h4, "aclr_st");
    // A second write lands while the call is still executing and must be refused.
    wr(`CCDE_A_INSN, {18'h0, 3'b100, 11'h005});
    wx(`CCDE_A_ACCUM, 32'h77, 4'hf, `CCDE_RESP_SLVERR);
    wait_idle();
    rc(`CCDE_A_ACCUM, 32'h0, "busy_accum");
    // A no-operation advances the program counter; an undecoded word advances it too and sets the illegal flag.
    wr(`CCDE_A_PC, 32'h20);
    ex(`CCDE_OPC_NOP);
    rc(`CCDE_A_PC, 32'h21, "nop_pc");
    wr(`CCDE_A_INSN, 32'h3fff);
    repeat (8) @(posedge aclk);
    rc(`CCDE_A_EXST, 32'h4, "illegal_flag");
    rc(`CCDE_A_PC, 32'h22, "illegal_pc");
    $display("test clear done");
    alu(`CCDE_OPC_FINV, 1'b0, 8'hff, 8'h00);
    alu(`CCDE_OPC_FINV, 1'b1, 8'h0f, 8'h1c);
    alu(`CCDE_OPC_FDEC, 1'b1, 8'h01, 8'h00);
    alu(`CCDE_OPC_FDEC, 1'b0, 8'h00, 8'h04);
    alu(`CCDE_OPC_DSKZ, 1'b1, 8'h01, 8'h18);
    alu(`CCDE_OPC_DSKZ, 1'b0, 8'h01, 8'h04);
    alu(`CCDE_OPC_DSKZ, 1'b0, 8'h05, 8'h04);
    alu(`CCDE_OPC_DSKZ, 1'b1, 8'h00, 8'h00);
    $display("test file ops done");
    end_of_test();
  end
endmodule // call_clear_decrement_exec_tb
